// ---- fmcd_buf_if.sv ----
// Port bundle between the command decoder and its write-page buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface fmcd_buf_if;
  import fmcd_pkg::*;
  logic wr_en;
  fmcd_idx_t wr_idx;
  fmcd_word_t wr_data;
  logic rd_en;
  fmcd_idx_t rd_idx;
  fmcd_word_t rd_data;
  modport ctrl (output wr_en, wr_idx, wr_data, rd_en, rd_idx, input rd_data);
  modport mem (input wr_en, wr_idx, wr_data, rd_en, rd_idx, output rd_data);
endinterface

`default_nettype wire

// ---- fmcd_cfg.svh ----
// Constants of the flash mode command decoder: offsets, command codes, reset values.
// Assumes word addressing on the host side, with the sector bits above the offset field.
`ifndef FMCD_CFG_SVH
`define FMCD_CFG_SVH

// -----------------------------------------------------------------------------
// Address layout
// -----------------------------------------------------------------------------
`define FMCD_ADDR_W 24
`define FMCD_OFS_W 12
`define FMCD_PAGE_BITS 5
`define FMCD_OFS_UNLOCK 12'h555
`define FMCD_OFS_SECOND 12'h2AA
`define FMCD_OFS_RESUME 12'h000
`define FMCD_REG_OFS 8'h00

// -----------------------------------------------------------------------------
// Command codes (low data byte only)
// -----------------------------------------------------------------------------
`define FMCD_CMD_CFG_ENTRY 8'hD0
`define FMCD_CMD_LOCK_ENTRY 8'h40
`define FMCD_CMD_SEC_ENTRY 8'h88
`define FMCD_CMD_LOAD 8'h25
`define FMCD_CMD_COMMIT 8'h29
`define FMCD_CMD_RESET 8'hF0
`define FMCD_CMD_STATUS 8'h70
`define FMCD_CMD_PROG_RESUME 8'h50
`define FMCD_CMD_ERASE_RESUME 8'h30
`define FMCD_CMD_BLANK 8'h33

// -----------------------------------------------------------------------------
// Limits and reset values
// -----------------------------------------------------------------------------
`define FMCD_MAX_WC 8'h1F
`define FMCD_CFG_RST 16'h8000
`define FMCD_CFG_ASYNC_BIT 15

`endif

// ---- fmcd_decoder.sv ----
// Command-sequence decoder for a multiplexed-bus flash: modes, page loads, commits.
// Assumes one host bus cycle per cycle_valid pulse, synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
`include "fmcd_cfg.svh"

module fmcd_decoder
  import fmcd_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Host bus cycles
  input wire logic cyc_valid,
  input wire logic cyc_write,
  input wire logic [`FMCD_ADDR_W-1:0] cyc_addr,
  input wire logic [15:0] cyc_wdata,
  output logic rd_valid,
  output logic [15:0] rd_data,
  // Read sources and engine state
  input wire logic [15:0] array_rdata,
  input wire logic [15:0] lock_rdata,
  input wire logic [15:0] secure_rdata,
  input wire logic [15:0] status_rdata,
  input wire logic banks_idle,
  input wire logic prog_suspended,
  input wire logic erase_suspended,
  // Commit stream and control pulses
  output logic prog_valid,
  output logic [1:0] prog_target,
  output logic [`FMCD_ADDR_W-1:0] prog_addr,
  output logic [15:0] prog_data,
  output logic prog_resume,
  output logic erase_resume,
  output logic blank_check,
  // Status
  output logic [15:0] config_word,
  output logic [1:0] mode,
  output logic busy,
  output logic seq_lost
);
  localparam int SEC_LO = `FMCD_OFS_W;

  fmcd_buf_if pbus ();
  fmcd_page_buf u_buf (.clock(clock), .bus(pbus));

  fmcd_state_e state_r;
  fmcd_mode_e mode_r;
  logic [`FMCD_ADDR_W-1:SEC_LO] sector_r;
  logic [`FMCD_ADDR_W-1:`FMCD_PAGE_BITS] page_r;
  fmcd_idx_t left_r, first_idx_r, last_idx_r, ptr_r;
  logic first_r;
  fmcd_word_t last_data_r, config_r, rd_data_r;
  logic rd_valid_r, prog_valid_r, prog_resume_r, erase_resume_r, blank_r;
  fmcd_addr_t prog_addr_r;
  logic [1:0] prog_target_r;

  // ---------------------------------------------------------------------------
  // Cycle decode
  // ---------------------------------------------------------------------------
  // Commands look at the low byte only, so a stray upper byte cannot alter them.
  logic wr, rd, at_unlock, is_reset, load_ok, wc_ok, commit_go, stream_en;
  logic [7:0] lo;
  logic [`FMCD_OFS_W-1:0] ofs;
  assign wr = cyc_valid & cyc_write;
  assign rd = cyc_valid & ~cyc_write;
  assign lo = cyc_wdata[7:0];
  assign ofs = cyc_addr[`FMCD_OFS_W-1:0];
  assign at_unlock = (ofs == `FMCD_OFS_UNLOCK);
  // A datum of F0 during a load is data, not a reset.
  assign is_reset = wr && (lo == `FMCD_CMD_RESET) && (state_r != ST_LOAD);
  // Word count must fit the page; register modes hold a single word.
  assign wc_ok = (ofs == `FMCD_OFS_SECOND) && (cyc_addr[`FMCD_ADDR_W-1:SEC_LO] == sector_r)
    && (lo <= `FMCD_MAX_WC) && ((mode_r == MD_ARRAY) || (mode_r == MD_SECURE) ||
    (lo == 8'h00));
  // The first word must lie in the load's sector and fixes the page; later words must climb within that page.
  always_comb begin
    if (first_r) begin
      load_ok = (cyc_addr[`FMCD_ADDR_W-1:SEC_LO] == sector_r) &&
        (((mode_r != MD_CFG) && (mode_r != MD_LOCK)) ||
        (cyc_addr[7:0] == `FMCD_REG_OFS));
    end else begin
      load_ok = (cyc_addr[`FMCD_ADDR_W-1:`FMCD_PAGE_BITS] == page_r) &&
        (cyc_addr[`FMCD_PAGE_BITS-1:0] > last_idx_r);
    end
  end
  assign commit_go = (state_r == ST_LOADED) && wr && at_unlock && (lo == `FMCD_CMD_COMMIT);
  assign stream_en = (state_r == ST_COMMIT) && !is_reset;

  // ---------------------------------------------------------------------------
  // Sequence state
  // ---------------------------------------------------------------------------
  // Any misstep traps the decoder until a reset command; this keeps half-built
  // loads from ever reaching the array.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
    end else if (is_reset) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (wr && at_unlock && lo == `FMCD_CMD_LOAD) begin
            state_r <= ST_COUNT;
          end else if (wr && at_unlock && lo == `FMCD_CMD_STATUS) begin
            state_r <= ST_STATUS;
          end
        end
        ST_COUNT: begin
          if (rd || (wr && !wc_ok)) begin
            state_r <= ST_LOST;
          end else if (wr) begin
            state_r <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (rd || (wr && !load_ok)) begin
            state_r <= ST_LOST;
          end else if (wr && left_r == '0) begin
            state_r <= ST_LOADED;
          end
        end
        ST_LOADED: begin
          if (commit_go) begin
            state_r <= (mode_r == MD_CFG) ? ST_IDLE : ST_COMMIT;
          end else if (cyc_valid) begin
            state_r <= ST_LOST;
          end
        end
        ST_STATUS: begin
          if (rd) begin
            state_r <= ST_IDLE;
          end else if (wr) begin
            state_r <= ST_LOST;
          end
        end
        ST_COMMIT: begin
          if (ptr_r == last_idx_r) begin
            state_r <= ST_IDLE;
          end
        end
        ST_LOST: state_r <= ST_LOST;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Load bookkeeping: sector, page, remaining count and word span.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sector_r <= '0;
      page_r <= '0;
      left_r <= '0;
      first_idx_r <= '0;
      last_idx_r <= '0;
      first_r <= 1'b0;
      last_data_r <= '0;
    end else if (state_r == ST_IDLE && wr && at_unlock && lo == `FMCD_CMD_LOAD) begin
      sector_r <= cyc_addr[`FMCD_ADDR_W-1:SEC_LO];
    end else if (state_r == ST_COUNT && wr) begin
      left_r <= lo[`FMCD_PAGE_BITS-1:0];
      first_r <= 1'b1;
    end else if (state_r == ST_LOAD && wr && load_ok) begin
      if (first_r) begin
        page_r <= cyc_addr[`FMCD_ADDR_W-1:`FMCD_PAGE_BITS];
        first_idx_r <= cyc_addr[`FMCD_PAGE_BITS-1:0];
      end
      last_idx_r <= cyc_addr[`FMCD_PAGE_BITS-1:0];
      last_data_r <= cyc_wdata;
      first_r <= 1'b0;
      left_r <= left_r - 1'b1;
    end
  end

  // Words go into the page buffer at their own page index.
  assign pbus.wr_en = (state_r == ST_LOAD) && wr && load_ok;
  assign pbus.wr_idx = cyc_addr[`FMCD_PAGE_BITS-1:0];
  assign pbus.wr_data = cyc_wdata;

  // ---------------------------------------------------------------------------
  // Mode state
  // ---------------------------------------------------------------------------
  // Entry is refused while any bank works, so a mode switch never lands mid-operation.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mode_r <= MD_ARRAY;
    end else if (is_reset) begin
      mode_r <= MD_ARRAY;
    end else if (state_r == ST_IDLE && wr && at_unlock && banks_idle &&
        mode_r == MD_ARRAY) begin
      case (lo)
        `FMCD_CMD_CFG_ENTRY: mode_r <= MD_CFG;
        `FMCD_CMD_LOCK_ENTRY: mode_r <= MD_LOCK;
        `FMCD_CMD_SEC_ENTRY: mode_r <= MD_SECURE;
        default: mode_r <= mode_r;
      endcase
    end
  end

  // The configuration word is committed from the single loaded datum.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      config_r <= `FMCD_CFG_RST;
    end else if (commit_go && mode_r == MD_CFG) begin
      config_r <= last_data_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Commit stream
  // ---------------------------------------------------------------------------
  // One buffered word per cycle, first index to last, tagged with the mode.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_r <= '0;
      prog_valid_r <= 1'b0;
      prog_addr_r <= '0;
      prog_target_r <= '0;
    end else begin
      prog_valid_r <= stream_en;
      if (commit_go) begin
        ptr_r <= first_idx_r;
      end else if (stream_en) begin
        ptr_r <= ptr_r + 1'b1;
        prog_addr_r <= {page_r, ptr_r};
        prog_target_r <= mode_r;
      end
    end
  end

  assign pbus.rd_en = stream_en;
  assign pbus.rd_idx = ptr_r;

  // ---------------------------------------------------------------------------
  // Reads and control pulses
  // ---------------------------------------------------------------------------
  // Reads are answered one cycle later: from the status word in ST_STATUS, else from the source the mode selects.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_valid_r <= 1'b0;
      rd_data_r <= '0;
    end else begin
      rd_valid_r <= rd;
      if (rd) begin
        if (state_r == ST_STATUS) begin
          rd_data_r <= status_rdata;
        end else begin
          case (mode_r)
            MD_CFG: rd_data_r <= (cyc_addr[7:0] == `FMCD_REG_OFS) ? config_r : '0;
            MD_LOCK: rd_data_r <= lock_rdata;
            MD_SECURE: rd_data_r <= secure_rdata;
            default: rd_data_r <= array_rdata;
          endcase
        end
      end
    end
  end

  // Resume and blank check fire only when their precondition holds, else vanish.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prog_resume_r <= 1'b0;
      erase_resume_r <= 1'b0;
      blank_r <= 1'b0;
    end else begin
      prog_resume_r <= (state_r == ST_IDLE) && wr && (ofs == `FMCD_OFS_RESUME) &&
        (lo == `FMCD_CMD_PROG_RESUME) && prog_suspended;
      erase_resume_r <= (state_r == ST_IDLE) && wr && (ofs == `FMCD_OFS_RESUME) &&
        (lo == `FMCD_CMD_ERASE_RESUME) && erase_suspended;
      blank_r <= (state_r == ST_IDLE) && wr && at_unlock && (lo == `FMCD_CMD_BLANK) &&
        config_r[`FMCD_CFG_ASYNC_BIT];
    end
  end

  assign rd_valid = rd_valid_r;
  assign rd_data = rd_data_r;
  assign prog_valid = prog_valid_r;
  assign prog_addr = prog_addr_r;
  assign prog_data = pbus.rd_data;
  assign prog_target = prog_target_r;
  assign prog_resume = prog_resume_r;
  assign erase_resume = erase_resume_r;
  assign blank_check = blank_r;
  assign config_word = config_r;
  assign mode = mode_r;
  assign busy = (state_r == ST_COMMIT);
  assign seq_lost = (state_r == ST_LOST);

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_reset_exit_mode: assert property (is_reset |=> mode_r == MD_ARRAY && state_r == ST_IDLE)
    else $error("reset command did not return to array read");
  a_entry_needs_idle: assert property (!banks_idle |=>
    mode_r == $past(mode_r) || mode_r == MD_ARRAY)
    else $error("mode entered while a bank was busy");
  a_cfg_read_value: assert property (rd && mode_r == MD_CFG && state_r != ST_STATUS &&
    cyc_addr[7:0] == 8'h00 |=> rd_valid && rd_data == config_r)
    else $error("config read returned wrong value");
  a_prog_resume_gate: assert property (prog_resume |-> $past(prog_suspended))
    else $error("program resume without suspend");
  a_erase_resume_gate: assert property (erase_resume |-> $past(erase_suspended))
    else $error("erase resume without suspend");
  a_blank_check_gate: assert property (blank_check |-> $past(config_r[15]))
    else $error("blank check outside asynchronous mode");
  a_lost_holds_trap: assert property (seq_lost && !is_reset |=> seq_lost)
    else $error("left trap without reset");
  a_count_too_big: assert property (state_r == ST_COUNT && wr && lo > 8'h1F && !is_reset |=>
    seq_lost)
    else $error("oversized word count accepted");
  a_read_answer: assert property (rd |=> rd_valid ##1 !rd_valid || $past(rd))
    else $error("read not answered in one cycle");
  a_commit_stream: assert property (commit_go && mode_r == MD_SECURE |=> ##1 prog_valid &&
    prog_target == 2'(MD_SECURE))
    else $error("commit did not stream to secure region");

  c_cfg_entry: cover property (mode_r == MD_ARRAY ##1 mode_r == MD_CFG);
  c_commit_done: cover property (busy ##1 !busy);
  c_secure_read: cover property (rd && mode_r == MD_SECURE);
  c_trap_reset: cover property (seq_lost ##1 !seq_lost);
endmodule

`default_nettype wire

// ---- fmcd_host_model.sv ----
// Host memory controller model: issues word-addressed bus cycles to the decoder.
// Assumes the decoder takes a cycle on the rising edge where cyc_valid is high.
`timescale 1ns/1ps
`default_nettype none

module fmcd_host_model
  import fmcd_pkg::*;
(
  // Clock
  input wire logic clock,
  // Bus cycles towards the decoder
  output var logic cyc_valid,
  output var logic cyc_write,
  output var fmcd_addr_t cyc_addr,
  output var fmcd_word_t cyc_wdata,
  // Read answer
  input wire logic rd_valid,
  input wire fmcd_word_t rd_data
);
  // ----------------------------------------------------------------
  // Bus cycle tasks
  // ----------------------------------------------------------------
  // Idle bus at time zero.
  initial begin
    cyc_valid = 1'b0;
    cyc_write = 1'b0;
    cyc_addr = '0;
    cyc_wdata = '0;
  end

  // One cycle: raised after an edge, held to the taking edge, then released.
  task automatic cyc(input logic w, input fmcd_addr_t a, input fmcd_word_t d);
    @(posedge clock);
    cyc_valid <= 1'b1;
    cyc_write <= w;
    cyc_addr <= a;
    cyc_wdata <= d;
    @(posedge clock);
    cyc_valid <= 1'b0;
    // Released lines show the inverse, so a stale value never looks valid.
    cyc_addr <= ~a;
    cyc_wdata <= ~d;
  endtask

  task automatic wr(input fmcd_addr_t a, input fmcd_word_t d);
    cyc(1'b1, a, d);
  endtask

  // Read cycle; the answer stands for the one cycle after the taking edge, so it is
  // looked at just inside that cycle, once the edge's register updates have landed.
  task automatic rd(input fmcd_addr_t a, output fmcd_word_t d, output logic v);
    cyc(1'b0, a, 16'h0000);
    #1;
    v = rd_valid;
    d = rd_data;
  endtask

  // Buffer load: code, word count, ascending words in one page, commit.
  task automatic load(input logic [11:0] sec, input logic [11:0] ofs, input int n,
                      input fmcd_word_t d0);
    wr({sec, 12'h555}, 16'h0025);
    wr({sec, 12'h2AA}, 16'(n - 1));
    for (int i = 0; i < n; i++) begin
      wr({sec, ofs + 12'(i)}, d0 + 16'(i));
    end
    wr({sec, 12'h555}, 16'h0029);
  endtask
endmodule

`default_nettype wire

// ---- fmcd_page_buf.sv ----
// Write-page buffer of 32 words with a registered read port.
// Assumes the decoder never reads and writes the same word in one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "fmcd_cfg.svh"

module fmcd_page_buf
  import fmcd_pkg::*;
(
  // Clock
  input wire logic clock,
  // Decoder side
  fmcd_buf_if.mem bus
);
  fmcd_word_t mem_r [0:(1<<`FMCD_PAGE_BITS)-1];
  fmcd_word_t rd_data_r;

  // Storage has no reset; a commit reads every index from first to last loaded word, so gaps in a load read back stale words.
  always_ff @(posedge clock) begin
    if (bus.wr_en) begin
      mem_r[bus.wr_idx] <= bus.wr_data;
    end
  end

  // Read data leaves through a register, one cycle after the request.
  always_ff @(posedge clock) begin
    if (bus.rd_en) begin
      rd_data_r <= mem_r[bus.rd_idx];
    end
  end

  assign bus.rd_data = rd_data_r;
endmodule

`default_nettype wire

// ---- fmcd_pkg.sv ----
// Types shared by the flash mode command decoder and its page buffer.
// Assumes fmcd_cfg.svh is on the include path.
`include "fmcd_cfg.svh"

package fmcd_pkg;
  typedef logic [15:0] fmcd_word_t;
  typedef logic [`FMCD_ADDR_W-1:0] fmcd_addr_t;
  typedef logic [`FMCD_PAGE_BITS-1:0] fmcd_idx_t;
  typedef enum logic [1:0] {MD_ARRAY, MD_CFG, MD_LOCK, MD_SECURE} fmcd_mode_e;
  typedef enum logic [2:0] {
    ST_IDLE, ST_COUNT, ST_LOAD, ST_LOADED, ST_STATUS, ST_COMMIT, ST_LOST
  } fmcd_state_e;
endpackage

// ---- testbench.sv ----
// Self-checking bench for the flash mode command decoder.
// Assumes the host model makes every bus cycle; engine levels come from here.
`timescale 1ns/1ps
`default_nettype none

module testbench
  import fmcd_pkg::*;
;
  localparam logic [11:0] SEC = 12'h3A5;
  logic clock, sys_rst, cyc_valid, cyc_write, rd_valid, banks_idle, v;
  logic prog_suspended, erase_suspended, prog_valid, prog_resume, erase_resume;
  logic blank_check, busy, seq_lost;
  logic [1:0] prog_target, mode;
  fmcd_addr_t cyc_addr, prog_addr;
  fmcd_word_t cyc_wdata, rd_data, array_rdata, lock_rdata, secure_rdata;
  fmcd_word_t status_rdata, prog_data, config_word, d;
  int fails = 0;
  int num_checks = 0;
  int n_pres = 0;
  int n_eres = 0;
  int n_blank = 0;
  logic [41:0] p_log[$];

  fmcd_decoder dut (.clock, .sys_rst, .cyc_valid, .cyc_write, .cyc_addr, .cyc_wdata,
    .rd_valid, .rd_data, .array_rdata, .lock_rdata, .secure_rdata, .status_rdata,
    .banks_idle, .prog_suspended, .erase_suspended, .prog_valid, .prog_target,
    .prog_addr, .prog_data, .prog_resume, .erase_resume, .blank_check, .config_word,
    .mode, .busy, .seq_lost);
  fmcd_host_model host (.clock, .cyc_valid, .cyc_write, .cyc_addr, .cyc_wdata,
    .rd_valid, .rd_data);

  // ----------------------------------------------------------------
  // Clock and pulse log
  // ----------------------------------------------------------------
  // Clock of 40 ns.
  always #20 clock = ~clock;

  // Strobes last one cycle, so they are counted at every edge.
  always @(posedge clock) begin
    if (prog_valid === 1'b1) begin
      p_log.push_back({prog_target, prog_addr, prog_data});
    end
    if (prog_resume === 1'b1) n_pres++;
    if (erase_resume === 1'b1) n_eres++;
    if (blank_check === 1'b1) n_blank++;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Let the edge's register updates land before looking.
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic final_report();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk({busy, seq_lost, mode, config_word}, {4'h0, 16'h8000});
    host.rd({SEC, 12'h123}, d, v);
    chk({v, d}, {1'b1, array_rdata});
    $display("test reset done");
  endtask

  // Entry refused while busy banks; resume gated by suspend levels; blank only fired in async mode.
  task automatic t_pulses();
    banks_idle <= 1'b0;
    host.wr({SEC, 12'h555}, 16'h00D0);
    idle(2);
    chk(mode, MD_ARRAY);
    banks_idle <= 1'b1;
    host.wr({SEC, 12'h000}, 16'h0050);
    host.wr({SEC, 12'h000}, 16'h0030);
    idle(2);
    chk(n_pres + n_eres, 0);
    prog_suspended <= 1'b1;
    erase_suspended <= 1'b1;
    host.wr({SEC, 12'h000}, 16'h0050);
    host.wr({SEC, 12'h000}, 16'h0030);
    host.wr({SEC, 12'h555}, 16'h0033);
    idle(2);
    chk({n_pres[3:0], n_eres[3:0], n_blank[3:0]}, 12'h111);
    prog_suspended <= 1'b0;
    erase_suspended <= 1'b0;
    host.wr({SEC, 12'h555}, 16'h0070);
    host.rd({SEC, 12'h000}, d, v);
    chk({v, d}, {1'b1, status_rdata});
    $display("test pulses done");
  endtask

  // Upper byte of a command is junk; config word is loaded and read at X00.
  task automatic t_cfg();
    host.wr({SEC, 12'h555}, 16'h5AD0);
    idle(2);
    chk(mode, MD_CFG);
    host.rd({SEC, 12'h700}, d, v);
    chk(d, 16'h8000);
    host.load(SEC, 12'h700, 1, 16'h0041);
    idle(3);
    chk({p_log.size(), config_word}, {32'd0, 16'h0041});
    host.rd({SEC, 12'h900}, d, v);
    chk(d, 16'h0041);
    host.wr({SEC, 12'h321}, 16'h00F0);
    host.wr({SEC, 12'h555}, 16'h0033);
    idle(2);
    chk({mode, n_blank[3:0]}, {MD_ARRAY, 4'h1});
    $display("test config done");
  endtask

  task automatic t_lock();
    host.wr({SEC, 12'h555}, 16'h0040);
    idle(2);
    chk(mode, MD_LOCK);
    host.rd({SEC, 12'h010}, d, v);
    chk(d, lock_rdata);
    host.load(SEC, 12'h000, 1, 16'hBEEF);
    idle(4);
    chk(p_log.size(), 1);
    chk(p_log[0], {MD_LOCK, SEC, 12'h000, 16'hBEEF});
    host.wr({SEC, 12'h000}, 16'h00F0);
    idle(2);
    chk(mode, MD_ARRAY);
    $display("test lock done");
  endtask

  // Two-word load mid-page; words stream out in ascending order.
  task automatic t_secure();
    host.wr({SEC, 12'h555}, 16'h0088);
    idle(2);
    chk(mode, MD_SECURE);
    host.rd({SEC, 12'h044}, d, v);
    chk(d, secure_rdata);
    host.load(SEC, 12'h043, 2, 16'hA5C3);
    idle(1);
    chk(busy, 1'b1);
    idle(5);
    chk({p_log.size(), busy}, {32'd3, 1'b0});
    chk(p_log[1], {MD_SECURE, SEC, 12'h043, 16'hA5C3});
    chk(p_log[2], {MD_SECURE, SEC, 12'h044, 16'hA5C4});
    host.wr({SEC, 12'h000}, 16'h00F0);
    idle(2);
    chk(mode, MD_ARRAY);
    $display("test secure done");
  endtask

  // A read inside a load, and an oversized count, both trap until reset.
  task automatic t_trap();
    host.wr({SEC, 12'h555}, 16'h0025);
    host.wr({SEC, 12'h2AA}, 16'h0001);
    host.rd({SEC, 12'h043}, d, v);
    idle(1);
    chk(seq_lost, 1'b1);
    host.wr({SEC, 12'h555}, 16'h0088);
    idle(2);
    chk({seq_lost, mode}, {1'b1, MD_ARRAY});
    host.wr({SEC, 12'h000}, 16'hFFF0);
    idle(2);
    chk(seq_lost, 1'b0);
    host.wr({SEC, 12'h555}, 16'h0025);
    host.wr({SEC, 12'h2AA}, 16'h0020);
    idle(2);
    chk(seq_lost, 1'b1);
    host.wr({SEC, 12'h000}, 16'h00F0);
    idle(2);
    chk({seq_lost, p_log.size()}, {1'b0, 32'd3});
    $display("test trap done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    banks_idle = 1'b1;
    prog_suspended = 1'b0;
    erase_suspended = 1'b0;
    array_rdata = 16'h1A2B;
    lock_rdata = 16'h3C4D;
    secure_rdata = 16'h5E6F;
    status_rdata = 16'h0080;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    idle(1);
    t_reset();
    t_pulses();
    t_cfg();
    t_lock();
    t_secure();
    t_trap();
    final_report();
  end

  // The run needs about 130 cycles; this cuts a hang short.
  initial begin
    repeat (3000) @(posedge clock);
    fails++;
    final_report();
  end
endmodule

`default_nettype wire
